// >>> core/racmd_map.svh
`ifndef RACMD_MAP_SVH
`define RACMD_MAP_SVH

// Command codes and frame lengths.
`define RAC_CMD_RD 8'h08
`define RAC_CMD_WR 8'h09
`define RAC_RD_LEN 8'h03
`define RAC_WR_LEN3 8'h03
`define RAC_WR_LEN4 8'h04
`define RAC_REG_SIZE 8'h01
`define RAC_LEN_ZERO 8'h00
`define RAC_PAY_MAX 8'h04
`define RAC_STEP 8'h01

// Payload byte positions.
`define RAC_P_ADDR 2'h0
`define RAC_P_FLAG 2'h1
`define RAC_P_DATA 2'h2
`define RAC_P_VAL 2'h3

// Bit fields inside data bytes.
`define RAC_FLD_BIT 0
`define RAC_MOD_FLD 7:4
`define RAC_GAIN_FLD 3:0

// Register addresses.
`define RAC_ADDR_WAKE 8'h62
`define RAC_ADDR_ARC 8'h69
`define RAC_ADDR_IDX 8'h68
`define RAC_ADDR_TW 8'h3a
`define RAC_ADDR_SYNC 8'h3b
`define RAC_ADDR_PSAVE 8'h3c

// Result codes and flag values.
`define RAC_RES_OK 8'h00
`define RAC_ERR_LEN 8'h82
`define RAC_FLAG_INC 8'h01
`define RAC_IDX_ARC 8'h01

// Wake-up event values.
`define RAC_WAKE_RST 8'h00
`define RAC_WAKE_TMO 8'h01
`define RAC_WAKE_TAG 8'h02

// Reset values and protocol defaults.
`define RAC_ARC_RST 8'h00
`define RAC_IDX_RST 8'h00
`define RAC_TW_DEF 8'h52
`define RAC_ARC_14A 8'hdf
`define RAC_ARC_14B 8'h2f
`define RAC_ARC_18092 8'h5f
`define RAC_ARC_15_30 8'h53
`define RAC_ARC_15_100 8'hd3

// Modulation index in percent per nibble code.
`define RAC_MOD_C1 4'h1
`define RAC_MOD_C2 4'h2
`define RAC_MOD_C3 4'h3
`define RAC_MOD_C4 4'h4
`define RAC_MOD_C5 4'h5
`define RAC_MOD_C6 4'h6
`define RAC_MOD_CD 4'hd
`define RAC_MOD_P1 7'h0a
`define RAC_MOD_P2 7'h11
`define RAC_MOD_P3 7'h19
`define RAC_MOD_P4 7'h1e
`define RAC_MOD_P5 7'h21
`define RAC_MOD_P6 7'h24
`define RAC_MOD_PD 7'h5f
`define RAC_MOD_NONE 7'h00

// Receiver gain in dB per nibble code.
`define RAC_GAIN_C0 4'h0
`define RAC_GAIN_C1 4'h1
`define RAC_GAIN_C3 4'h3
`define RAC_GAIN_C7 4'h7
`define RAC_GAIN_CF 4'hf
`define RAC_GAIN_D0 6'h22
`define RAC_GAIN_D1 6'h20
`define RAC_GAIN_D3 6'h1b
`define RAC_GAIN_D7 6'h14
`define RAC_GAIN_DF 6'h08
`define RAC_GAIN_NONE 6'h00

// Response byte counts.
`define RAC_RESP_NONE 2'h0
`define RAC_RESP_SHORT 2'h2
`define RAC_RESP_LONG 2'h3
`define RAC_RESP_STEP 2'h1

`endif

// >>> core/racmd_pkg.sv
package racmd_pkg;

  typedef logic [7:0] racmd_byte_t;

  typedef enum logic [1:0] {
    S_CMD  = 2'h0,
    S_LEN  = 2'h1,
    S_PAY  = 2'h3,
    S_EXEC = 2'h2
  } racmd_state_e;

  typedef enum logic [2:0] {
    P_14443A   = 3'h0,
    P_14443B   = 3'h1,
    P_18092    = 3'h2,
    P_15693_30 = 3'h3,
    P_15693_100 = 3'h4
  } racmd_proto_e;

endpackage

// >>> core/racmd_resp.sv
`timescale 1ns/1ps
`include "racmd_map.svh"

module racmd_resp (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_arst_n,
  // Response load
  input wire logic i_start,
  input wire racmd_pkg::racmd_byte_t i_byte0,
  input wire racmd_pkg::racmd_byte_t i_byte1,
  input wire racmd_pkg::racmd_byte_t i_byte2,
  input wire logic i_three,
  output logic o_busy,
  // Byte stream to host
  output racmd_pkg::racmd_byte_t o_tx_data,
  output logic o_tx_valid,
  input wire logic i_tx_ready
);

  racmd_pkg::racmd_byte_t data_q, data_d, next1_q, next1_d, next2_q, next2_d;
  logic [1:0] left_q, left_d;

  assign o_tx_valid = (left_q != `RAC_RESP_NONE);
  assign o_busy = o_tx_valid;
  assign o_tx_data = data_q;

  always_comb begin
    data_d = data_q;
    next1_d = next1_q;
    next2_d = next2_q;
    left_d = left_q;
    if (i_start && !o_tx_valid) begin
      data_d = i_byte0;
      next1_d = i_byte1;
      next2_d = i_byte2;
      left_d = i_three ? `RAC_RESP_LONG : `RAC_RESP_SHORT;
    end else if (o_tx_valid && i_tx_ready) begin
      data_d = next1_q;
      next1_d = next2_q;
      left_d = left_q - `RAC_RESP_STEP;
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      data_q <= `RAC_LEN_ZERO;
      next1_q <= `RAC_LEN_ZERO;
      next2_q <= `RAC_LEN_ZERO;
      left_q <= `RAC_RESP_NONE;
    end else begin
      data_q <= data_d;
      next1_q <= next1_d;
      next2_q <= next2_d;
      left_q <= left_d;
    end
  end

endmodule

// >>> core/racmd_top.sv
// Summary of operation
// [RULE_01] Read frame is 08, length 03, address, size 01, reserved zero byte.
// [RULE_02] Read address 62 gives wake-up event, 69 gives analog RF byte.
// [RULE_03] Good read answers 00, byte count, then the register data.
// [RULE_04] Wake-up event reads 01 after timeout, 02 after tag detection.
// [RULE_05] Read with wrong length answers 82 then zero length, no data.
// [RULE_06] Host sets analog index through address 68 before reading analog byte.
// [RULE_07] Write frame is 09, length 03 or 04, address, flag, data; answer 00 00.
// [RULE_08] First write data byte is a flag selecting index auto-increment.
// [RULE_09] Index 01 selects analog byte; four-byte write also stores the value.
// [RULE_10] Analog byte holds modulation code high, receiver gain code low.
// [RULE_11] Analog value holds until next protocol selection or write; lost at power off.
// [RULE_12] Protocol selection loads DF, 2F, 5F, 53 or D3 per protocol.
// [RULE_13] Modulation codes 1,2,3,4,5,6,D mean 10,17,25,30,33,36,95 percent.
// [RULE_14] Gain codes 0,1,3,7,F mean 34,32,27,20,8 dB.
// [RULE_15] Host writes only nibbles permitted for the selected protocol.
// [RULE_16] Power-save bit clear allows reader mode; set cuts transmitter supply.
// [RULE_17] Write command also sets demodulation timing window and sync filter.
// [RULE_18] Host selects protocol, sets index, reads, writes, then reads back.
// [RULE_19] Analog index stays until a later write changes or increments it.
`timescale 1ns/1ps
`include "racmd_map.svh"

module racmd_top (
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_ARST_N,
  // Command bytes from host interface
  input wire racmd_pkg::racmd_byte_t I_RX_DATA,
  input wire logic I_RX_VALID,
  output logic O_RX_READY,
  // Response bytes to host interface
  output racmd_pkg::racmd_byte_t O_TX_DATA,
  output logic O_TX_VALID,
  input wire logic I_TX_READY,
  // Wake-up and protocol selection events
  input wire logic I_WAKE_BY_TIMEOUT,
  input wire logic I_WAKE_BY_TAG,
  input wire logic I_PROTO_LOAD,
  input wire logic [2:0] I_PROTO_SEL,
  // Configuration outputs
  output racmd_pkg::racmd_byte_t O_ANALOG_RF_CONFIG,
  output racmd_pkg::racmd_byte_t O_ARC_INDEX,
  output logic [6:0] O_MOD_INDEX_PCT,
  output logic [5:0] O_RX_GAIN_DB,
  output racmd_pkg::racmd_byte_t O_DEMOD_TIMING_WINDOW,
  output logic O_SYNC_ASSIST_FILTER,
  output logic O_TX_SUPPLY_POWER_SAVE_BIT
);

  racmd_pkg::racmd_state_e state_q, state_d;
  racmd_pkg::racmd_byte_t cmd_q, cmd_d, len_q, len_d, cnt_q, cnt_d;
  racmd_pkg::racmd_byte_t pay_q [4];
  racmd_pkg::racmd_byte_t pay_d [4];
  racmd_pkg::racmd_byte_t wake_q, wake_d, arc_q, arc_d, idx_q, idx_d, tw_q, tw_d;
  logic sync_q, sync_d, psave_q, psave_d;
  logic [6:0] pct_q, pct_d;
  logic [5:0] gain_q, gain_d;
  logic rx_take, rsp_busy, rsp_start, rsp_three;
  racmd_pkg::racmd_byte_t rsp_b0, rsp_b1, rsp_b2;
  logic exec_go;

  assign O_RX_READY = (state_q != racmd_pkg::S_EXEC);
  assign rx_take = I_RX_VALID && O_RX_READY;
  assign exec_go = (state_q == racmd_pkg::S_EXEC) && !rsp_busy;
  assign O_ANALOG_RF_CONFIG = arc_q;
  assign O_ARC_INDEX = idx_q;
  assign O_MOD_INDEX_PCT = pct_q;
  assign O_RX_GAIN_DB = gain_q;
  assign O_DEMOD_TIMING_WINDOW = tw_q;
  assign O_SYNC_ASSIST_FILTER = sync_q;
  assign O_TX_SUPPLY_POWER_SAVE_BIT = psave_q;

  always_comb begin
    state_d = state_q;
    cmd_d = cmd_q;
    len_d = len_q;
    cnt_d = cnt_q;
    pay_d = pay_q;
    wake_d = wake_q;
    arc_d = arc_q;
    // [RULE_19] Index holds otherwise.
    idx_d = idx_q;
    tw_d = tw_q;
    sync_d = sync_q;
    psave_d = psave_q;
    rsp_start = 1'b0;
    rsp_three = 1'b0;
    rsp_b0 = `RAC_RES_OK;
    rsp_b1 = `RAC_LEN_ZERO;
    rsp_b2 = `RAC_LEN_ZERO;
    // [RULE_04] Wake-up event capture.
    if (I_WAKE_BY_TAG) begin
      wake_d = `RAC_WAKE_TAG;
    end else if (I_WAKE_BY_TIMEOUT) begin
      wake_d = `RAC_WAKE_TMO;
    end
    case (state_q)
      racmd_pkg::S_CMD: begin
        if (rx_take) begin
          cmd_d = I_RX_DATA;
          state_d = racmd_pkg::S_LEN;
        end
      end
      racmd_pkg::S_LEN: begin
        if (rx_take) begin
          len_d = I_RX_DATA;
          cnt_d = `RAC_LEN_ZERO;
          state_d = (I_RX_DATA == `RAC_LEN_ZERO) ? racmd_pkg::S_EXEC : racmd_pkg::S_PAY;
        end
      end
      racmd_pkg::S_PAY: begin
        // Bytes past the fourth are swallowed so a long frame cannot desync the parser.
        if (rx_take) begin
          if (cnt_q < `RAC_PAY_MAX) begin
            pay_d[cnt_q[1:0]] = I_RX_DATA;
          end
          cnt_d = cnt_q + `RAC_STEP;
          if ((cnt_q + `RAC_STEP) == len_q) begin
            state_d = racmd_pkg::S_EXEC;
          end
        end
      end
      racmd_pkg::S_EXEC: begin
        if (!rsp_busy) begin
          state_d = racmd_pkg::S_CMD;
          if (cmd_q == `RAC_CMD_RD) begin
            rsp_start = 1'b1;
            // [RULE_01] Read frame decode.
            if (len_q != `RAC_RD_LEN || pay_q[`RAC_P_FLAG] != `RAC_REG_SIZE) begin
              // [RULE_05] Wrong length error.
              rsp_b0 = `RAC_ERR_LEN;
            // [RULE_02] Read address select.
            end else if (pay_q[`RAC_P_ADDR] == `RAC_ADDR_WAKE) begin
              // [RULE_03] Good read answer.
              rsp_b1 = `RAC_REG_SIZE;
              rsp_b2 = wake_q;
              rsp_three = 1'b1;
            end else if (pay_q[`RAC_P_ADDR] == `RAC_ADDR_ARC && idx_q == `RAC_IDX_ARC) begin
              rsp_b1 = `RAC_REG_SIZE;
              rsp_b2 = arc_q;
              rsp_three = 1'b1;
            end else begin
              rsp_b0 = `RAC_ERR_LEN;
            end
          end else if (cmd_q == `RAC_CMD_WR) begin
            rsp_start = 1'b1;
            if (len_q != `RAC_WR_LEN3 && len_q != `RAC_WR_LEN4) begin
              rsp_b0 = `RAC_ERR_LEN;
            end else begin
              // [RULE_07] Write decode and store.
              case (pay_q[`RAC_P_ADDR])
                `RAC_ADDR_IDX: begin
                  idx_d = pay_q[`RAC_P_DATA];
                  // [RULE_09] Value store at index.
                  if (len_q == `RAC_WR_LEN4 && pay_q[`RAC_P_DATA] == `RAC_IDX_ARC) begin
                    arc_d = pay_q[`RAC_P_VAL];
                  end
                  // [RULE_08] Index auto-increment.
                  if (pay_q[`RAC_P_FLAG] == `RAC_FLAG_INC) begin
                    idx_d = pay_q[`RAC_P_DATA] + `RAC_STEP;
                  end
                end
                // [RULE_17] Timing window write.
                `RAC_ADDR_TW: begin
                  tw_d = pay_q[`RAC_P_DATA];
                end
                // [RULE_17] Sync filter write.
                `RAC_ADDR_SYNC: begin
                  sync_d = pay_q[`RAC_P_DATA][`RAC_FLD_BIT];
                end
                // [RULE_16] Power-save bit write.
                `RAC_ADDR_PSAVE: begin
                  psave_d = pay_q[`RAC_P_DATA][`RAC_FLD_BIT];
                end
                default: begin
                end
              endcase
            end
          end
        end
      end
      default: begin
        state_d = racmd_pkg::S_CMD;
      end
    endcase
    // [RULE_12] Protocol defaults load.
    if (I_PROTO_LOAD) begin
      tw_d = `RAC_TW_DEF;
      sync_d = 1'b0;
      case (I_PROTO_SEL)
        racmd_pkg::P_14443A: arc_d = `RAC_ARC_14A;
        racmd_pkg::P_14443B: arc_d = `RAC_ARC_14B;
        racmd_pkg::P_18092: arc_d = `RAC_ARC_18092;
        racmd_pkg::P_15693_30: arc_d = `RAC_ARC_15_30;
        racmd_pkg::P_15693_100: arc_d = `RAC_ARC_15_100;
        default: arc_d = arc_q;
      endcase
    end
  end

  // Decodes follow arc_d so they line up with arc_q, not a cycle behind.
  always_comb begin
    // [RULE_10] Nibble split; [RULE_13] modulation map.
    case (arc_d[`RAC_MOD_FLD])
      `RAC_MOD_C1: pct_d = `RAC_MOD_P1;
      `RAC_MOD_C2: pct_d = `RAC_MOD_P2;
      `RAC_MOD_C3: pct_d = `RAC_MOD_P3;
      `RAC_MOD_C4: pct_d = `RAC_MOD_P4;
      `RAC_MOD_C5: pct_d = `RAC_MOD_P5;
      `RAC_MOD_C6: pct_d = `RAC_MOD_P6;
      `RAC_MOD_CD: pct_d = `RAC_MOD_PD;
      default: pct_d = `RAC_MOD_NONE;
    endcase
    // [RULE_14] Receiver gain map.
    case (arc_d[`RAC_GAIN_FLD])
      `RAC_GAIN_C0: gain_d = `RAC_GAIN_D0;
      `RAC_GAIN_C1: gain_d = `RAC_GAIN_D1;
      `RAC_GAIN_C3: gain_d = `RAC_GAIN_D3;
      `RAC_GAIN_C7: gain_d = `RAC_GAIN_D7;
      `RAC_GAIN_CF: gain_d = `RAC_GAIN_DF;
      default: gain_d = `RAC_GAIN_NONE;
    endcase
  end

  // [RULE_11] Registers are volatile.
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      state_q <= racmd_pkg::S_CMD;
      cmd_q <= `RAC_LEN_ZERO;
      len_q <= `RAC_LEN_ZERO;
      cnt_q <= `RAC_LEN_ZERO;
      pay_q <= '{default: `RAC_LEN_ZERO};
      wake_q <= `RAC_WAKE_RST;
      arc_q <= `RAC_ARC_RST;
      idx_q <= `RAC_IDX_RST;
      tw_q <= `RAC_TW_DEF;
      sync_q <= 1'b0;
      psave_q <= 1'b0;
      pct_q <= `RAC_MOD_NONE;
      gain_q <= `RAC_GAIN_D0;
    end else begin
      state_q <= state_d;
      cmd_q <= cmd_d;
      len_q <= len_d;
      cnt_q <= cnt_d;
      pay_q <= pay_d;
      wake_q <= wake_d;
      arc_q <= arc_d;
      idx_q <= idx_d;
      tw_q <= tw_d;
      sync_q <= sync_d;
      psave_q <= psave_d;
      pct_q <= pct_d;
      gain_q <= gain_d;
    end
  end

  racmd_resp u_resp (
    .i_clock(I_CLOCK),
    .i_arst_n(I_ARST_N),
    .i_start(rsp_start),
    .i_byte0(rsp_b0),
    .i_byte1(rsp_b1),
    .i_byte2(rsp_b2),
    .i_three(rsp_three),
    .o_busy(rsp_busy),
    .o_tx_data(O_TX_DATA),
    .o_tx_valid(O_TX_VALID),
    .i_tx_ready(I_TX_READY)
  );

  a_read_wake_ok: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N) // [RULE_03]
    exec_go && cmd_q == `RAC_CMD_RD && len_q == `RAC_RD_LEN && pay_q[`RAC_P_FLAG] == `RAC_REG_SIZE
    && pay_q[`RAC_P_ADDR] == `RAC_ADDR_WAKE |=> O_TX_VALID && O_TX_DATA == `RAC_RES_OK
    && u_resp.next1_q == `RAC_REG_SIZE && u_resp.next2_q == $past(wake_q))
    else $error("read of wake register did not answer ok and count");

  a_read_len_err: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N) // [RULE_05]
    exec_go && cmd_q == `RAC_CMD_RD && len_q != `RAC_RD_LEN
    |=> O_TX_VALID && O_TX_DATA == `RAC_ERR_LEN)
    else $error("bad read length gave no error code");

  a_wake_tag_val: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N) // [RULE_04]
    I_WAKE_BY_TAG |=> wake_q == `RAC_WAKE_TAG)
    else $error("tag wake-up not recorded");

  a_wake_tmo_val: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N) // [RULE_04]
    I_WAKE_BY_TIMEOUT && !I_WAKE_BY_TAG |=> wake_q == `RAC_WAKE_TMO)
    else $error("timeout wake-up not recorded");

  a_proto_default: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N) // [RULE_12]
    I_PROTO_LOAD && I_PROTO_SEL == racmd_pkg::P_18092
    |=> arc_q == `RAC_ARC_18092 && tw_q == `RAC_TW_DEF && !sync_q)
    else $error("protocol selection did not load defaults");

  a_arc_hold: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N) // [RULE_11]
    !I_PROTO_LOAD && !(exec_go && cmd_q == `RAC_CMD_WR) |=> $stable(arc_q))
    else $error("analog byte changed without cause");

  a_index_hold: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N) // [RULE_19]
    !exec_go |=> $stable(idx_q))
    else $error("analog index changed outside a write");

  a_index_incr: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N) // [RULE_08]
    exec_go && cmd_q == `RAC_CMD_WR && (len_q == `RAC_WR_LEN3 || len_q == `RAC_WR_LEN4)
    && pay_q[`RAC_P_ADDR] == `RAC_ADDR_IDX && pay_q[`RAC_P_FLAG] == `RAC_FLAG_INC
    |=> idx_q == $past(pay_q[`RAC_P_DATA]) + `RAC_STEP)
    else $error("index did not auto-increment");

  a_arc_store: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N) // [RULE_09]
    exec_go && cmd_q == `RAC_CMD_WR && len_q == `RAC_WR_LEN4 && pay_q[`RAC_P_ADDR] == `RAC_ADDR_IDX
    && pay_q[`RAC_P_DATA] == `RAC_IDX_ARC && !I_PROTO_LOAD |=> arc_q == $past(pay_q[`RAC_P_VAL]))
    else $error("four-byte write did not store analog byte");

  a_mod_decode: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N) // [RULE_13]
    arc_q[`RAC_MOD_FLD] == `RAC_MOD_CD |-> O_MOD_INDEX_PCT == `RAC_MOD_PD)
    else $error("modulation code D not 95 percent");

  a_gain_decode: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N) // [RULE_14]
    arc_q[`RAC_GAIN_FLD] == `RAC_GAIN_CF |-> O_RX_GAIN_DB == `RAC_GAIN_DF)
    else $error("gain code F not 8 dB");

endmodule

// >>> test/racmd_host.sv
`timescale 1ns/1ps

module racmd_host (
  // Clock
  input wire logic i_clock,
  // Command bytes to the block
  output racmd_pkg::racmd_byte_t o_rx_data,
  output logic o_rx_valid,
  input wire logic i_rx_ready,
  // Response bytes from the block
  input wire racmd_pkg::racmd_byte_t i_tx_data,
  input wire logic i_tx_valid,
  output logic o_tx_ready
);
  bit slow = 1'b0;

  initial begin
    o_rx_data = 8'h00;
    o_rx_valid = 1'b0;
    o_tx_ready = 1'b0;
  end

  task automatic rd_frame(input racmd_pkg::racmd_byte_t a, output racmd_pkg::racmd_byte_t f[$]);
    f = {8'h08, 8'h03, a, 8'h01, 8'h00};
  endtask

  task automatic wr_frame(input racmd_pkg::racmd_byte_t a, fl, d, v, input bit four,
                          output racmd_pkg::racmd_byte_t f[$]);
    f = {8'h09, four ? 8'h04 : 8'h03, a, fl, d};
    if (four) begin
      f.push_back(v);
    end
  endtask

  // Each byte is held until a rising edge that finds the block ready, or that follows 40 more falling edges without ready.
  task automatic send(input racmd_pkg::racmd_byte_t f[$], output bit ok);
    ok = 1'b1;
    foreach (f[i]) begin
      @(negedge i_clock);
      o_rx_data = f[i];
      o_rx_valid = 1'b1;
      repeat (40) if (i_rx_ready !== 1'b1) @(negedge i_clock);
      if (i_rx_ready !== 1'b1) begin
        ok = 1'b0;
      end
      @(posedge i_clock);
    end
    @(negedge i_clock);
    o_rx_valid = 1'b0;
    // An idle line shows the inverted last byte, so a stale byte is never read as fresh data.
    o_rx_data = ~o_rx_data;
  endtask

  task automatic recv(input int cnt, output racmd_pkg::racmd_byte_t r[$], output bit ok);
    int n;
    r = {};
    n = 0;
    while (r.size() < cnt && n < 200) begin
      @(negedge i_clock);
      n++;
      // A slow host withholds ready on every other cycle.
      o_tx_ready = !(slow && n[0]);
      if (o_tx_ready && i_tx_valid === 1'b1) begin
        r.push_back(i_tx_data);
        @(posedge i_clock);
      end
    end
    @(negedge i_clock);
    o_tx_ready = 1'b0;
    ok = (r.size() == cnt);
  endtask
endmodule

// >>> test/register_access_commands_bench.sv
`timescale 1ns/1ps

module register_access_commands_bench;
  typedef racmd_pkg::racmd_byte_t racb_t;
  logic clk, arst_n, rx_valid, rx_ready, tx_valid, tx_ready;
  logic wake_tmo, wake_tag, proto_load, sync, psave;
  logic [2:0] proto_sel;
  logic [6:0] pct;
  logic [5:0] db;
  racb_t rx_data, tx_data, arc, idx, tw;
  int mismatches = 0;
  int samples_checked = 0;
  racb_t dflt[5] = '{8'hdf, 8'h2f, 8'h5f, 8'h53, 8'hd3};
  logic [3:0] mc[7] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hd};
  racb_t mp[7] = '{8'h0a, 8'h11, 8'h19, 8'h1e, 8'h21, 8'h24, 8'h5f};
  logic [3:0] gc[5] = '{4'h0, 4'h1, 4'h3, 4'h7, 4'hf};
  racb_t gd[5] = '{8'h22, 8'h20, 8'h1b, 8'h14, 8'h08};
  // Protocol that permits each modulation code, so every write stays legal.
  logic [2:0] mpr[7] = '{3'h2, 3'h2, 3'h2, 3'h2, 3'h3, 3'h3, 3'h0};

  racmd_top dut (.I_CLOCK(clk), .I_ARST_N(arst_n), .I_RX_DATA(rx_data), .I_RX_VALID(rx_valid),
    .O_RX_READY(rx_ready), .O_TX_DATA(tx_data), .O_TX_VALID(tx_valid), .I_TX_READY(tx_ready),
    .I_WAKE_BY_TIMEOUT(wake_tmo), .I_WAKE_BY_TAG(wake_tag), .I_PROTO_LOAD(proto_load),
    .I_PROTO_SEL(proto_sel), .O_ANALOG_RF_CONFIG(arc), .O_ARC_INDEX(idx), .O_MOD_INDEX_PCT(pct),
    .O_RX_GAIN_DB(db), .O_DEMOD_TIMING_WINDOW(tw), .O_SYNC_ASSIST_FILTER(sync),
    .O_TX_SUPPLY_POWER_SAVE_BIT(psave));

  racmd_host host (.i_clock(clk), .o_rx_data(rx_data), .o_rx_valid(rx_valid), .i_rx_ready(rx_ready),
    .i_tx_data(tx_data), .i_tx_valid(tx_valid), .o_tx_ready(tx_ready));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic final_report;
    $display("Checks made %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic xact(input racb_t f[$], input racb_t e[$]);
    racb_t r[$];
    bit ok1, ok2;
    host.send(f, ok1);
    host.recv(e.size(), r, ok2);
    if (!(ok1 && ok2)) begin
      mismatches++;
      final_report();
    end
    foreach (e[i]) check("response byte", r[i], e[i]);
    check("response idle", {7'h00, tx_valid}, 8'h00);
  endtask

  task automatic rd(input racb_t a, input racb_t e[$]);
    racb_t f[$];
    host.rd_frame(a, f);
    xact(f, e);
  endtask

  task automatic wr(input racb_t a, fl, d, v, input bit four);
    racb_t f[$];
    host.wr_frame(a, fl, d, v, four, f);
    xact(f, {8'h00, 8'h00});
  endtask

  task automatic pulse(input int k, input logic [2:0] p);
    @(negedge clk);
    wake_tmo = (k == 0);
    wake_tag = (k == 1);
    proto_load = (k == 2);
    proto_sel = p;
    @(negedge clk);
    wake_tmo = 1'b0;
    wake_tag = 1'b0;
    proto_load = 1'b0;
  endtask

  initial begin
    arst_n = 1'b0;
    wake_tmo = 1'b0;
    wake_tag = 1'b0;
    proto_load = 1'b0;
    proto_sel = 3'h0;
    repeat (20) @(negedge clk);
    arst_n = 1'b1;
    check("analog byte", arc, 8'h00);
    check("index", idx, 8'h00);
    check("window", tw, 8'h52);
    check("filter", {7'h00, sync}, 8'h00);
    check("power save", {7'h00, psave}, 8'h00);
    rd(8'h62, {8'h00, 8'h01, 8'h00});
    pulse(0, 3'h0);
    rd(8'h62, {8'h00, 8'h01, 8'h01});
    pulse(1, 3'h0);
    host.slow = 1'b1;
    rd(8'h62, {8'h00, 8'h01, 8'h02});
    host.slow = 1'b0;
    xact({8'h08, 8'h02, 8'h62, 8'h01}, {8'h82, 8'h00});
    xact({8'h08, 8'h03, 8'h62, 8'h02, 8'h00}, {8'h82, 8'h00});
    rd(8'h69, {8'h82, 8'h00});
    xact({8'h09, 8'h02, 8'h68, 8'h00}, {8'h82, 8'h00});
    for (int p = 0; p < 5; p++) begin
      pulse(2, p[2:0]);
      check("protocol default", arc, dflt[p]);
    end
    // Select, index, read, write, read back.
    pulse(2, 3'h2);
    wr(8'h68, 8'h00, 8'h01, 8'h00, 1'b0);
    check("index", idx, 8'h01);
    rd(8'h69, {8'h00, 8'h01, 8'h5f});
    rd(8'h69, {8'h00, 8'h01, 8'h5f});
    wr(8'h68, 8'h01, 8'h01, 8'h23, 1'b1);
    check("index", idx, 8'h02);
    rd(8'h69, {8'h82, 8'h00});
    wr(8'h68, 8'h00, 8'h01, 8'h00, 1'b0);
    rd(8'h69, {8'h00, 8'h01, 8'h23});
    for (int i = 0; i < 7; i++) begin
      host.slow = i[0];
      pulse(2, mpr[i]);
      wr(8'h68, 8'h00, 8'h01, {mc[i], gc[i % 5]}, 1'b1);
      check("analog byte", arc, {mc[i], gc[i % 5]});
      check("modulation", {1'b0, pct}, mp[i]);
      check("gain", {2'b00, db}, gd[i % 5]);
    end
    host.slow = 1'b0;
    wr(8'h40, 8'h00, 8'h01, 8'h00, 1'b0);
    wr(8'h3a, 8'h00, 8'h58, 8'h04, 1'b1);
    check("window", tw, 8'h58);
    wr(8'h3b, 8'h00, 8'h01, 8'h00, 1'b0);
    check("filter", {7'h00, sync}, 8'h01);
    wr(8'h3c, 8'h00, 8'h01, 8'h00, 1'b0);
    check("power save", {7'h00, psave}, 8'h01);
    check("analog byte", arc, 8'hd1);
    pulse(2, 3'h4);
    check("analog byte", arc, 8'hd3);
    check("window", tw, 8'h52);
    check("filter", {7'h00, sync}, 8'h00);
    check("power save", {7'h00, psave}, 8'h01);
    arst_n = 1'b0;
    @(negedge clk);
    arst_n = 1'b1;
    check("analog byte", arc, 8'h00);
    rd(8'h62, {8'h00, 8'h01, 8'h00});
    final_report();
  end
endmodule
